/* audio_port_defs.svh */
`ifndef AUDIO_PORT_DEFS_SVH
`define AUDIO_PORT_DEFS_SVH

// ********************************
// Register addresses and reset value
// ********************************
`define AP_ADDR_DATA 16'h3810
`define AP_ADDR_CTRL 16'h3812
`define AP_CTRL_RESET 16'h8012
`define AP_CFG_MASK 16'hFDF0

// ********************************
// Control register field positions
// ********************************
`define AP_B_TYPE 15
`define AP_B_OEN 14
`define AP_B_IEN 13
`define AP_B_DIV_HI 12
`define AP_B_DIV_LO 10
`define AP_B_SRST 9
`define AP_B_SWE 8
`define AP_B_LWE 7
`define AP_B_OLEN 6
`define AP_B_ILEN 5
`define AP_B_ROLE 4
`define AP_B_SERR 3
`define AP_B_LERR 2
`define AP_B_SEF 1
`define AP_B_LEF 0

// ********************************
// Counts
// ********************************
`define AP_DIV_MAX 3'h5
`define AP_LAST_WORD_32 2'h1
`define AP_LAST_WORD_64 2'h3
`define AP_LAST_BIT_32 6'h1F
`define AP_LAST_BIT_64 6'h3F

`endif

/* audio_port_pkg.sv */
package audio_port_pkg;

	typedef logic [2:0] div_code_t;

	typedef enum logic [2:0] {
		IN_IDLE = 3'b001,
		IN_SHIFT = 3'b010,
		IN_MOVE = 3'b100
	} in_state_e;

	// Five bits wide, since the slowest bit clock ratio is sixteen
	function automatic logic [4:0] bclk_ratio(input div_code_t c);
		case (c)
			3'h0: bclk_ratio = 5'h04;
			3'h1: bclk_ratio = 5'h08;
			3'h2: bclk_ratio = 5'h06;
			3'h3: bclk_ratio = 5'h0C;
			3'h4: bclk_ratio = 5'h08;
			default: bclk_ratio = 5'h10;
		endcase
	endfunction

	function automatic logic [9:0] lr_ratio(input div_code_t c);
		case (c)
			3'h0, 3'h1: lr_ratio = 10'h100;
			3'h2, 3'h3: lr_ratio = 10'h180;
			default: lr_ratio = 10'h200;
		endcase
	endfunction

	// Which 16-bit lane of the 64-bit word a given access hits
	function automatic logic [1:0] word_lane(input logic len32, input logic [1:0] idx);
		word_lane = len32 ? (2'h1 - idx) : (2'h3 - idx);
	endfunction

endpackage

/* audio_clock_gen.sv */
`timescale 1ns/1ps
module audio_clock_gen (
	input wire logic clock, // System clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic run, // Master mode active
	input wire logic mclk_rise, // Synchronised master clock rising edge
	input wire audio_port_pkg::div_code_t div_code, // Division select
	output logic bclk, // Generated bit clock
	output logic lrclk // Generated left/right clock
);
	import audio_port_pkg::*;

	logic [4:0] bdiv;
	logic [9:0] ldiv;
	logic [4:0] bcnt_r, bcnt_nxt;
	logic [9:0] lcnt_r, lcnt_nxt;
	logic bclk_r, lrclk_r;

	assign bdiv = bclk_ratio(div_code);
	assign ldiv = lr_ratio(div_code);
	assign bcnt_nxt = (bcnt_r == bdiv - 5'h01) ? 5'h00 : bcnt_r + 5'h01;
	assign lcnt_nxt = (lcnt_r == ldiv - 10'h001) ? 10'h000 : lcnt_r + 10'h001;
	assign bclk = bclk_r;
	assign lrclk = lrclk_r;

	// Both counters start together, so every left/right fall lands on a bit clock fall
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bcnt_r <= 5'h00;
			lcnt_r <= 10'h000;
			bclk_r <= 1'b1;
			lrclk_r <= 1'b1;
		end else if (!run) begin
			bcnt_r <= 5'h00;
			lcnt_r <= 10'h000;
			bclk_r <= 1'b1;
			lrclk_r <= 1'b1;
		end else if (mclk_rise) begin
			bcnt_r <= bcnt_nxt;
			lcnt_r <= lcnt_nxt;
			bclk_r <= (bcnt_nxt >= (bdiv >> 1));
			lrclk_r <= (lcnt_nxt < (ldiv >> 1));
		end
	end

endmodule // audio_clock_gen

/* audio_port.sv */
// How it works
// (RL1) 16-bit control/status register, resets to 0x8012
// (RL2) 64-bit output shifter reloads from holding register
// (RL3) 64-bit input shifter hands word to holding
// (RL4) Bit 15 selects standard or audio operation
// (RL5) Bits 14/13 enable output and input paths
// (RL6) Bits 12:10 pick bit and frame clock ratios
// (RL7) Software sets division before master mode only
// (RL8) Bit 9 resets flags, then self-clears
// (RL9) Software waits three cycles after soft reset
// (RL10) Soft reset never shares a write
// (RL11) Bits 8/7 stall stores and loads when unready
// (RL12) Bits 6/5 choose 64 or 32 bit frames
// (RL13) Bit 4 selects master or slave clocking
// (RL14) Software never returns from master to slave
// (RL15) Error flags set on bad access, clear by 0
// (RL16) Enable flags set on transfer, clear on access
// (RL17) Enable flags drop after two or four accesses
// (RL18) Output loads after frame start, shifts MSB first
// (RL19) Store flag rises after left/right clock falls
// (RL20) Input word moves, load flag one edge later
// (RL21) Input frame starts on first rise after fall
// (RL22) Serial output undefined until first frame
// (RL23) Software moves words upper half first
// (RL24) Frame spans 32 or 64 bit clocks
// (RL25) Master drives divided clocks, slave uses pins
// (RL26) Reserved division codes keep previous ratio
`timescale 1ns/1ps
`include "audio_port_defs.svh"
module audio_port (
	input wire logic clock, // System clock, 50 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic [15:0] bus_addr, // Peripheral bus address
	input wire logic [15:0] bus_wdata, // Store data
	input wire logic bus_store, // Store request, held until ack
	input wire logic bus_load, // Load request, held until ack
	output logic [15:0] bus_rdata, // Load data, valid with ack
	output logic bus_ack, // Request taken last cycle
	output logic bus_wait, // Request is being stalled
	input wire logic mclk, // Master clock pin
	input wire logic bclk_in, // Bit clock pin, input side
	output logic bclk_out, // Bit clock pin, output side
	output logic bclk_oe, // Bit clock drive enable
	input wire logic lrclk_in, // Left/right clock pin, input side
	output logic lrclk_out, // Left/right clock pin, output side
	output logic lrclk_oe, // Left/right clock drive enable
	input wire logic serial_data_in, // Serial input pin
	output logic serial_data_out, // Serial output pin
	output logic store_enable_flag, // Output word wanted
	output logic load_enable_flag // Input word ready
);
	import audio_port_pkg::*;

	localparam logic [15:0] RST = `AP_CTRL_RESET;

	// ****************************************
	// Pin synchronisers and clock selection
	// ****************************************
	logic [3:0] sync1_r, sync2_r;
	logic mclk_prev_r, bclk_prev_r, lr_prev_r, oe_r;
	logic gen_bclk, gen_lrclk, master, bclk_sel, lr_sel;
	logic mclk_rise, bclk_rise, bclk_fall, lr_fall, din;

	// ****************************************
	// Register state
	// ****************************************
	logic [15:0] cfg_r, cfg_nxt, ctrl_view;
	logic srst_r, serr_r, lerr_r, sef_r, lef_r, lef_pend_r;
	logic [1:0] st_idx_r, ld_idx_r, st_lane, ld_lane;
	logic [15:0] rdata_r, in_word;
	logic ack_r, wait_r;
	logic [63:0] out_hold_r, in_hold_r, osh_r, ish_r;
	logic arm_r, sdo_r;
	logic [5:0] in_cnt_r;
	in_state_e in_state_r;

	logic active, out_on, in_on, olen32, ilen32;
	logic hit_data, hit_ctrl, st_data, ld_data, st_ctrl, ld_ctrl;
	logic st_stall, ld_stall, req, take, st_take, ld_take, st_last, ld_last;
	logic sef_set, div_ok;
	logic [5:0] in_last;

	assign master = ~cfg_r[`AP_B_ROLE];
	assign bclk_sel = master ? gen_bclk : sync2_r[0]; // RL25
	assign lr_sel = master ? gen_lrclk : sync2_r[1]; // RL25
	assign mclk_rise = sync2_r[2] & ~mclk_prev_r;
	assign bclk_rise = bclk_sel & ~bclk_prev_r;
	assign bclk_fall = ~bclk_sel & bclk_prev_r;
	assign lr_fall = ~lr_sel & lr_prev_r;
	assign din = sync2_r[3];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Idle pin levels, so no false clock edge follows reset
			sync1_r <= 4'h3;
			sync2_r <= 4'h3;
			mclk_prev_r <= 1'b0;
			bclk_prev_r <= 1'b1;
			lr_prev_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			sync1_r <= {serial_data_in, mclk, lrclk_in, bclk_in};
			sync2_r <= sync1_r;
			mclk_prev_r <= sync2_r[2];
			bclk_prev_r <= bclk_sel;
			lr_prev_r <= lr_sel;
			oe_r <= master; // RL13
		end
	end

	// Changing the ratio while the divider runs garbles the clocks
	audio_clock_gen u_clock_gen (
		.clock(clock),
		.resetn(resetn),
		.run(master), // RL13
		.mclk_rise(mclk_rise),
		.div_code(cfg_r[`AP_B_DIV_HI:`AP_B_DIV_LO]), // RL6
		.bclk(gen_bclk),
		.lrclk(gen_lrclk)
	);

	assign bclk_out = gen_bclk;
	assign lrclk_out = gen_lrclk;
	assign bclk_oe = oe_r;
	assign lrclk_oe = oe_r;

	// ****************************************
	// Bus decode
	// ****************************************
	assign active = cfg_r[`AP_B_TYPE]; // RL4
	assign out_on = active & cfg_r[`AP_B_OEN]; // RL5
	assign in_on = active & cfg_r[`AP_B_IEN]; // RL5
	assign olen32 = cfg_r[`AP_B_OLEN]; // RL12
	assign ilen32 = cfg_r[`AP_B_ILEN]; // RL12
	assign hit_data = bus_addr == `AP_ADDR_DATA;
	assign hit_ctrl = bus_addr == `AP_ADDR_CTRL;
	assign st_data = bus_store & hit_data;
	assign ld_data = bus_load & hit_data;
	assign st_ctrl = bus_store & hit_ctrl;
	assign ld_ctrl = bus_load & hit_ctrl;
	// Stores also wait while a frame start is armed, so the old word is not overwritten
	assign st_stall = st_data & ((~sef_r & cfg_r[`AP_B_SWE]) | arm_r | sef_set); // RL11
	assign ld_stall = ld_data & ~lef_r & cfg_r[`AP_B_LWE]; // RL11
	assign req = bus_store | bus_load;
	assign take = req & ~st_stall & ~ld_stall;
	assign st_take = st_data & ~st_stall;
	assign ld_take = ld_data & ~ld_stall;
	assign st_lane = word_lane(olen32, st_idx_r); // RL23
	assign ld_lane = word_lane(ilen32, ld_idx_r); // RL23
	assign st_last = st_take & sef_r &
		(st_idx_r == (olen32 ? `AP_LAST_WORD_32 : `AP_LAST_WORD_64)); // RL17
	assign ld_last = ld_take & lef_r &
		(ld_idx_r == (ilen32 ? `AP_LAST_WORD_32 : `AP_LAST_WORD_64)); // RL17
	assign in_word = in_hold_r[{ld_lane, 4'h0} +: 16];
	assign sef_set = out_on & lr_fall; // RL19

	// ****************************************
	// Control register
	// ****************************************
	assign div_ok = bus_wdata[`AP_B_DIV_HI:`AP_B_DIV_LO] <= `AP_DIV_MAX;
	always_comb begin
		cfg_nxt = bus_wdata & `AP_CFG_MASK;
		if (!div_ok) begin
			cfg_nxt[`AP_B_DIV_HI:`AP_B_DIV_LO] = cfg_r[`AP_B_DIV_HI:`AP_B_DIV_LO]; // RL26
		end
	end
	assign ctrl_view = cfg_r | {6'h00, srst_r, 5'h00, serr_r, lerr_r, sef_r, lef_r}; // RL1

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= RST & `AP_CFG_MASK; // RL1
			srst_r <= 1'b0;
		end else begin
			srst_r <= st_ctrl & bus_wdata[`AP_B_SRST]; // RL8
			if (st_ctrl && !bus_wdata[`AP_B_SRST]) begin
				cfg_r <= cfg_nxt;
			end
		end
	end

	// ****************************************
	// Flags and word counters
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sef_r <= RST[`AP_B_SEF];
			lef_r <= RST[`AP_B_LEF];
			serr_r <= 1'b0;
			lerr_r <= 1'b0;
			st_idx_r <= 2'h0;
			ld_idx_r <= 2'h0;
		end else if (srst_r) begin
			sef_r <= 1'b1; // RL8
			lef_r <= 1'b0; // RL8
			serr_r <= 1'b0; // RL8
			lerr_r <= 1'b0; // RL8
			st_idx_r <= 2'h0;
			ld_idx_r <= 2'h0;
		end else begin
			if (sef_set) begin
				sef_r <= 1'b1; // RL16
				st_idx_r <= 2'h0;
			end else if (st_take && sef_r) begin
				st_idx_r <= st_idx_r + 2'h1;
				if (st_last) begin
					sef_r <= 1'b0; // RL17
				end
			end
			if (lef_pend_r) begin
				lef_r <= 1'b1; // RL20
				ld_idx_r <= 2'h0;
			end else if (ld_take && lef_r) begin
				ld_idx_r <= ld_idx_r + 2'h1;
				if (ld_last) begin
					lef_r <= 1'b0; // RL17
				end
			end
			// Hardware set wins over a software clear in the same cycle
			if (st_take && !sef_r) begin
				serr_r <= 1'b1; // RL15
			end else if (st_ctrl && !bus_wdata[`AP_B_SERR]) begin
				serr_r <= 1'b0; // RL15
			end
			if (ld_take && !lef_r) begin
				lerr_r <= 1'b1; // RL15
			end else if (st_ctrl && !bus_wdata[`AP_B_LERR]) begin
				lerr_r <= 1'b0; // RL15
			end
		end
	end

	assign store_enable_flag = sef_r;
	assign load_enable_flag = lef_r;

	// ****************************************
	// Bus answers
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= 16'h0000;
			ack_r <= 1'b0;
			wait_r <= 1'b0;
		end else begin
			ack_r <= take;
			wait_r <= req & ~take; // RL11
			if (take && bus_load) begin
				rdata_r <= ld_ctrl ? ctrl_view : (ld_data ? in_word : 16'h0000);
			end
		end
	end

	assign bus_rdata = rdata_r;
	assign bus_ack = ack_r;
	assign bus_wait = wait_r;

	// ****************************************
	// Serial paths
	// ****************************************
	assign in_last = ilen32 ? `AP_LAST_BIT_32 : `AP_LAST_BIT_64; // RL24

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			arm_r <= 1'b0;
			sdo_r <= 1'b0;
			in_cnt_r <= 6'h00;
			in_state_r <= IN_IDLE;
			lef_pend_r <= 1'b0;
		end else begin
			lef_pend_r <= (in_state_r == IN_MOVE) & ~srst_r; // RL20
			if (srst_r) begin
				arm_r <= 1'b0;
			end else if (sef_set) begin
				arm_r <= 1'b1; // RL18
			end else if (bclk_rise) begin
				arm_r <= 1'b0;
			end
			if (bclk_fall && out_on) begin
				sdo_r <= osh_r[63]; // RL18
			end
			if (srst_r) begin
				in_state_r <= IN_IDLE;
			end else begin
				unique case (in_state_r)
					IN_IDLE: begin
						if (in_on && lr_fall) begin
							in_state_r <= IN_SHIFT; // RL21
							in_cnt_r <= 6'h00;
						end
					end
					IN_SHIFT: begin
						if (bclk_rise) begin
							in_cnt_r <= in_cnt_r + 6'h01;
							if (in_cnt_r == in_last) begin
								in_state_r <= IN_MOVE; // RL3
							end
						end
					end
					IN_MOVE: in_state_r <= IN_IDLE;
					default: in_state_r <= IN_IDLE;
				endcase
			end
		end
	end

	// Data registers carry no reset: the shifter holds garbage until its first load
	always_ff @(posedge clock) begin
		if (st_take && sef_r) begin
			out_hold_r[{st_lane, 4'h0} +: 16] <= bus_wdata;
		end
		if (bclk_rise && arm_r) begin
			osh_r <= olen32 ? {out_hold_r[31:0], 32'h00000000} : out_hold_r; // RL2
		end else if (bclk_fall && out_on) begin
			osh_r <= {osh_r[62:0], 1'b0}; // RL22
		end
		if (in_state_r == IN_SHIFT && bclk_rise) begin
			ish_r <= {ish_r[62:0], din}; // RL3
		end
		if (in_state_r == IN_MOVE) begin
			in_hold_r <= ilen32 ? {32'h00000000, ish_r[31:0]} : ish_r; // RL20
		end
	end

	assign serial_data_out = sdo_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_srst_flags;
		srst_r |=> sef_r && !lef_r && !serr_r && !lerr_r && !srst_r;
	endproperty
	a_srst_flags: assert property (p_srst_flags) else $error("soft reset flags wrong"); // RL8

	property p_store_err;
		st_take && !sef_r && !srst_r |=> serr_r;
	endproperty
	a_store_err: assert property (p_store_err) else $error("store error not set"); // RL15

	property p_load_err;
		ld_take && !lef_r && !srst_r |=> lerr_r ##1 (lerr_r || srst_r || $past(st_ctrl));
	endproperty
	a_load_err: assert property (p_load_err) else $error("load error not set"); // RL15

	property p_store_wait;
		st_data && !sef_r && cfg_r[`AP_B_SWE] |=> bus_wait && !bus_ack;
	endproperty
	a_store_wait: assert property (p_store_wait) else $error("store not stalled"); // RL11

	property p_load_wait;
		ld_data && !lef_r && cfg_r[`AP_B_LWE] |=> bus_wait && !bus_ack;
	endproperty
	a_load_wait: assert property (p_load_wait) else $error("load not stalled"); // RL11

	property p_sef_rise;
		sef_set && !srst_r |=> store_enable_flag;
	endproperty
	a_sef_rise: assert property (p_sef_rise) else $error("store flag late"); // RL19

	property p_lef_rise;
		in_state_r == IN_MOVE && !srst_r |=> ##1 (load_enable_flag || $past(srst_r));
	endproperty
	a_lef_rise: assert property (p_lef_rise) else $error("load flag late"); // RL20

	property p_sef_drop;
		$fell(sef_r) |-> $past(st_last) || $past(srst_r);
	endproperty
	a_sef_drop: assert property (p_sef_drop) else $error("store flag fell early"); // RL17

	property p_div_hold;
		st_ctrl && !bus_wdata[`AP_B_SRST] && !div_ok
		|=> $stable(cfg_r[`AP_B_DIV_HI:`AP_B_DIV_LO]);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("reserved division taken"); // RL26

	property p_oe_role;
		$fell(cfg_r[`AP_B_ROLE]) |=> ##1 bclk_oe && lrclk_oe;
	endproperty
	a_oe_role: assert property (p_oe_role) else $error("clock pins not driven"); // RL25

	c_store_frame: cover property (st_last ##[1:1000] sef_set);
	c_input_word: cover property (in_state_r == IN_MOVE ##2 load_enable_flag);
	c_master_run: cover property (master && gen_bclk ##1 !gen_bclk);

endmodule // audio_port

/* audio_codec_model.sv */
`timescale 1ns/1ps
// ********
// Slave-side codec: makes both clocks, sends and hears words
// ********
module audio_codec_model #(
	parameter int HALF_NS = 200
) (
	input wire logic start, // Rising edge starts a run
	input wire logic [7:0] frames, // Frames in one run
	input wire logic [6:0] frame_bits, // Bit clocks per frame
	input wire logic [63:0] tx_word, // Word sent every frame
	input wire logic serial_data_out, // Device serial output
	output logic bclk, // Bit clock, still between runs
	output logic lrclk, // Left/right clock
	output logic serial_data_in, // Device serial input
	output logic [63:0] rx_word, // Last whole word heard
	output logic busy // Run in progress
);
	logic [63:0] shift_r;
	initial begin
		bclk = 1'b1;
		lrclk = 1'b1;
		serial_data_in = 1'b1;
		rx_word = 64'h0;
		shift_r = 64'h0;
		busy = 1'b0;
		forever begin
			@(posedge start);
			busy = 1'b1;
			for (int f = 0; f < frames; f++) begin
				for (int i = 0; i < frame_bits; i++) begin
					bclk = 1'b0;
					lrclk = (i >= frame_bits / 2);
					serial_data_in = tx_word[frame_bits - 1 - i];
					#HALF_NS;
					bclk = 1'b1;
					shift_r = {shift_r[62:0], serial_data_out};
					// Output before the first frame is junk, so it is never kept
					if (i == 0 && f > 0) begin
						rx_word = shift_r;
					end
					#HALF_NS;
				end
			end
			// Released data line shows the inverse of its last bit
			serial_data_in = ~serial_data_in;
			busy = 1'b0;
		end
	end
endmodule // audio_codec_model

/* tb_audio_serial_port_control.sv */
`timescale 1ns/1ps
`include "audio_port_defs.svh"
module tb_audio_serial_port_control;
	localparam int LIMIT = 40000;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic mclk = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [15:0] bus_wdata = 16'h0000;
	logic bus_store = 1'b0;
	logic bus_load = 1'b0;
	logic [15:0] bus_rdata;
	logic bus_ack, bus_wait, bclk_out, bclk_oe, lrclk_out, lrclk_oe;
	logic serial_data_in, serial_data_out, store_enable_flag, load_enable_flag;
	logic codec_start = 1'b0;
	logic [63:0] codec_tx = 64'h0;
	logic [63:0] codec_rx;
	logic codec_bclk, codec_lrclk, codec_busy, bclk_pin, lrclk_pin;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	int mclk_count = 0;

	// Pin level: the device drives only while its enable is high
	assign bclk_pin = bclk_oe ? bclk_out : codec_bclk;
	assign lrclk_pin = lrclk_oe ? lrclk_out : codec_lrclk;

	always #10 clock = ~clock;
	// Offset keeps master clock edges apart from system clock edges
	initial begin
		#5;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) mclk_count++;

	audio_port DUT (
		.clock(clock), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_store(bus_store), .bus_load(bus_load), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .bus_wait(bus_wait), .mclk(mclk), .bclk_in(bclk_pin),
		.bclk_out(bclk_out), .bclk_oe(bclk_oe), .lrclk_in(lrclk_pin),
		.lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .store_enable_flag(store_enable_flag),
		.load_enable_flag(load_enable_flag)
	);

	audio_codec_model CODEC (
		.start(codec_start), .frames(8'd2), .frame_bits(7'd32), .tx_word(codec_tx),
		.serial_data_out(serial_data_out), .bclk(codec_bclk), .lrclk(codec_lrclk),
		.serial_data_in(serial_data_in), .rx_word(codec_rx), .busy(codec_busy)
	);

	// ********
	// Checks, bus cycles and closing
	// ********
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_word({15'h0, got}, {15'h0, exp}, what);
	endtask

	task automatic chk_num(input int got, input int exp, input string what);
		chk_word(got[15:0], exp[15:0], what);
	endtask

	// Request is held until the ack shows, then dropped inside the ack cycle
	task automatic bus_access(input logic wr, input logic [15:0] addr, input logic [15:0] wd,
			output logic [15:0] rd, output logic stalled);
		int n;
		n = 0;
		stalled = 1'b0;
		@(posedge clock);
		#2;
		bus_addr = addr;
		bus_wdata = wd;
		bus_store = wr;
		bus_load = !wr;
		do begin
			@(posedge clock);
			#2;
			if (bus_wait === 1'b1) stalled = 1'b1;
			n++;
		end while (bus_ack !== 1'b1 && n < 4000);
		rd = bus_rdata;
		bus_store = 1'b0;
		bus_load = 1'b0;
		if (n >= 4000) chk_bit(1'b0, 1'b1, "bus hang");
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic s;
		bus_access(1'b1, a, d, r, s);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
		logic [15:0] r;
		logic s;
		bus_access(1'b0, a, 16'h0000, r, s);
		chk_word(r, exp, what);
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			$display("[FAIL] %0t run timed out", $time);
			complete_run();
		end
	end

	// ********
	// Tests
	// ********
	task automatic t_reset();
		rd_chk(`AP_ADDR_CTRL, `AP_CTRL_RESET, "ctrl reset");
		chk_bit(store_enable_flag, 1'b1, "store flag reset");
		chk_bit(load_enable_flag, 1'b0, "load flag reset");
		$display("test reset done");
	endtask

	task automatic t_config();
		wr(`AP_ADDR_CTRL, 16'hF470);
		rd_chk(`AP_ADDR_CTRL, 16'hF472, "div code 5");
		wr(`AP_ADDR_CTRL, 16'hF870);
		rd_chk(`AP_ADDR_CTRL, 16'hF472, "div reserved");
		wr(`AP_ADDR_CTRL, 16'hE070);
		rd_chk(`AP_ADDR_CTRL, 16'hE072, "slave 32 bit");
		rd_chk(16'h3811, 16'h0000, "unmapped");
		$display("test config done");
	endtask

	task automatic t_errors();
		logic [15:0] r;
		logic s;
		bus_access(1'b0, `AP_ADDR_DATA, 16'h0000, r, s);
		rd_chk(`AP_ADDR_CTRL, 16'hE076, "load error");
		wr(`AP_ADDR_DATA, 16'hC35A);
		chk_bit(store_enable_flag, 1'b1, "store flag after one");
		wr(`AP_ADDR_DATA, 16'h96E1);
		rd_chk(`AP_ADDR_CTRL, 16'hE074, "store flag after two");
		chk_bit(store_enable_flag, 1'b0, "store flag pin");
		wr(`AP_ADDR_DATA, 16'h1234);
		rd_chk(`AP_ADDR_CTRL, 16'hE07C, "store error");
		wr(`AP_ADDR_CTRL, 16'hE078);
		rd_chk(`AP_ADDR_CTRL, 16'hE078, "error cleared by zero");
		wr(`AP_ADDR_CTRL, 16'h0200);
		repeat (3) @(posedge clock);
		rd_chk(`AP_ADDR_CTRL, 16'hE072, "soft reset");
		$display("test errors done");
	endtask

	task automatic t_stream();
		logic [15:0] r;
		logic s;
		int n;
		wr(`AP_ADDR_DATA, 16'hC35A);
		wr(`AP_ADDR_DATA, 16'h96E1);
		wr(`AP_ADDR_CTRL, 16'hE1F0);
		codec_tx = 64'h0000_0000_5AA5_1E87;
		codec_start = 1'b1;
		bus_access(1'b1, `AP_ADDR_DATA, 16'hABCD, r, s);
		chk_bit(s, 1'b1, "store stalled");
		bus_access(1'b0, `AP_ADDR_DATA, 16'h0000, r, s);
		chk_bit(s, 1'b1, "load stalled");
		chk_word(r, 16'h5AA5, "input upper");
		rd_chk(`AP_ADDR_DATA, 16'h1E87, "input lower");
		chk_bit(load_enable_flag, 1'b0, "load flag after two");
		codec_start = 1'b0;
		n = 0;
		while (codec_busy !== 1'b0 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		chk_word(codec_rx[31:16], 16'hC35A, "output upper");
		chk_word(codec_rx[15:0], 16'h96E1, "output lower");
		chk_bit(store_enable_flag, 1'b1, "store flag after frame");
		$display("test stream done");
	endtask

	task automatic t_master();
		int a;
		int n;
		wr(`AP_ADDR_CTRL, 16'hE000);
		rd_chk(`AP_ADDR_CTRL, 16'hE003, "master mode");
		rd_chk(`AP_ADDR_DATA, 16'h0000, "64 bit word 63:48");
		rd_chk(`AP_ADDR_DATA, 16'h0000, "64 bit word 47:32");
		rd_chk(`AP_ADDR_DATA, 16'h5AA5, "64 bit word 31:16");
		rd_chk(`AP_ADDR_DATA, 16'h1E87, "64 bit word 15:0");
		chk_bit(load_enable_flag, 1'b0, "load flag after four");
		n = 0;
		while (bclk_oe !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		chk_bit(bclk_oe, 1'b1, "bit clock driven");
		chk_bit(lrclk_oe, 1'b1, "frame clock driven");
		@(posedge bclk_out);
		@(posedge bclk_out);
		a = mclk_count;
		@(posedge bclk_out);
		chk_num(mclk_count - a, 4, "bit clock ratio");
		@(negedge lrclk_out);
		a = mclk_count;
		@(negedge lrclk_out);
		chk_num(mclk_count - a, 256, "frame clock ratio");
		$display("test master done");
	endtask

	initial begin
		repeat (16) @(posedge clock);
		#2;
		resetn = 1'b1;
		t_reset();
		t_config();
		t_errors();
		t_stream();
		t_master();
		complete_run();
	end
endmodule // tb_audio_serial_port_control
